// ### rtl/seau_core.sv
// Sensor event action unit: samples three sensor ports, turns level
// changes or threshold crossings into events, issues bound actions.
// Assumes asynchronous sensor pins, an external converter and an NVM agent.
//
// Added by the designer: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module seau_core
  import seau_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYC
)
(
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        reset_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  // Sensor pins and converter
  input  wire logic        sensor_port_one_in,
  input  wire logic        sensor_port_two_in,
  input  wire logic        sensor_port_three_in,
  input  wire logic [11:0] adc_data_in,
  output logic             adc_sample_out,
  output logic             adc_channel_out,
  // Action requests to the motion engine
  output logic             action_valid_out,
  output logic      [3:0]  action_code_out,
  output logic             motion_run_out,
  output logic             motion_move_out,
  output logic      [1:0]  dir_sel_out,
  output logic             decel_stop_out,
  output logic             estop_out,
  output logic             motor_off_out,
  output logic             clear_pos_out,
  // Host notification
  output logic             change_notification_out,
  output logic      [2:0]  notify_event_out,
  // Parameter store
  output logic             store_params_out,
  input  wire logic        store_ack_in
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0]       sy1;
    logic [2:0]       sy2;
    logic [2:0]       lvl;
    logic [2:0]       lock;
    logic [2:0][16:0] blank;
    logic [5:0]       pend;
    logic [15:0]      master_configuration;
    logic [15:0]      bind12;
    logic [15:0]      bind3;
    logic [11:0]      lower;
    logic [11:0]      upper;
    logic [11:0]      mean;
    logic [31:0]      intvl;
    logic [15:0]      ms_cnt;
    logic             ms_tick;
    logic [8:0]       smp_cnt;
    logic             smp;
    logic             acq;
    logic [3:0]       acq_n;
    logic [15:0]      acc;
    logic             upd;
    logic             wr;
    logic             rdw;
    logic [7:0]       addr;
    logic [31:0]      rdata;
    logic             av;
    logic [3:0]       code;
    logic             run;
    logic             move;
    logic [1:0]       dir;
    logic             decel;
    logic             estop;
    logic             off;
    logic             clr;
    logic             nv;
    logic [2:0]       nid;
    logic             store;
  } seau_state_t;

  seau_state_t s_reg;
  seau_state_t s_next;

  // Helper terms shared by logic and checks
  logic [2:0]  ana;
  logic        cont_mode;
  logic        single_mode;
  logic        aphase;
  logic [2:0]  en;
  logic [23:0] codes;

  // ----------------------------------------------------------------
  // Decoded configuration
  // ----------------------------------------------------------------
  // Port two never goes analog; the select bit steers one or three
  assign ana[0] = s_reg.master_configuration[ANE_BIT] & ~s_reg.master_configuration[CHS_BIT];
  assign ana[1] = 1'b0;
  assign ana[2] = s_reg.master_configuration[ANE_BIT] & s_reg.master_configuration[CHS_BIT];
  assign cont_mode   = (s_reg.intvl == 32'h0);
  assign single_mode = (s_reg.intvl > 32'(INTVL_MAX));
  assign en    = {s_reg.master_configuration[IE3_BIT], s_reg.master_configuration[IE2_BIT], s_reg.master_configuration[IE1_BIT]};
  assign codes = {s_reg.bind3[7:0], s_reg.bind12};
  // Address phase of a transfer that this slave takes
  assign aphase = hsel_in & htrans_in[1] & hready_in;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic       nl;
    logic       chg;
    logic [5:0] set;
    logic       found;
    int         idx;
    logic [3:0] c;
    nl    = 1'b0;
    chg   = 1'b0;
    set   = 6'h00;
    found = 1'b0;
    idx   = 0;
    c     = ACT_NONE;
    s_next = s_reg;

    // Two-stage synchroniser; only the second stage is looked at
    s_next.sy1 = {sensor_port_three_in, sensor_port_two_in, sensor_port_one_in};
    s_next.sy2 = s_reg.sy1;

    // Millisecond and conversion time bases
    s_next.ms_tick = 1'b0;
    if (s_reg.ms_cnt == 16'(MS_CYCLES - 1))
    begin
      s_next.ms_cnt  = 16'h0000;
      s_next.ms_tick = 1'b1;
    end
    else
      s_next.ms_cnt = s_reg.ms_cnt + 16'h0001;
    s_next.smp = 1'b0;
    if (s_reg.smp_cnt == 9'(SMP_CYC - 1))
    begin
      s_next.smp_cnt = 9'h000;
      s_next.smp     = 1'b1;
    end
    else
      s_next.smp_cnt = s_reg.smp_cnt + 9'h001;

    // Each millisecond gather 16 conversions and publish their mean
    s_next.upd = 1'b0;
    if (s_reg.ms_tick)
    begin
      s_next.acq   = 1'b1;
      s_next.acq_n = 4'h0;
      s_next.acc   = 16'h0000;
    end
    else if (s_reg.acq && s_reg.smp)
    begin
      s_next.acc   = s_reg.acc + 16'(adc_data_in);
      s_next.acq_n = s_reg.acq_n + 4'h1;
      if (s_reg.acq_n == 4'(AVG_N - 1))
      begin
        s_next.acq  = 1'b0;
        s_next.mean = s_next.acc[AVG_SH +: 12];
        s_next.upd  = 1'b1;
      end
    end

    // Register writes land in the data phase
    s_next.wr = 1'b0;
    if (store_ack_in)
      s_next.store = 1'b0;
    if (s_reg.wr)
    begin
      unique case (s_reg.addr)
        A_MASTER_CONFIGURATION:   s_next.master_configuration = hwdata_in[15:0];
        A_BIND12:
        begin
          s_next.bind12    = hwdata_in[15:0];
          s_next.lock[1:0] = 2'b00;
        end
        A_BIND3:
        begin
          s_next.bind3   = hwdata_in[15:0];
          s_next.lock[2] = 1'b0;
        end
        A_LOWER:  s_next.lower = hwdata_in[11:0];
        A_UPPER:  s_next.upper = hwdata_in[11:0];
        A_INTVL:  s_next.intvl = hwdata_in;
        A_STORE:  s_next.store = s_next.store | hwdata_in[0];
        default:  ;
      endcase
    end

    // Reads wait one cycle so a preceding write is always visible
    if (s_reg.rdw)
    begin
      s_next.rdw = 1'b0;
      unique case (s_reg.addr)
        A_MASTER_CONFIGURATION:   s_next.rdata = {16'h0000, s_reg.master_configuration};
        A_BIND12: s_next.rdata = {16'h0000, s_reg.bind12};
        A_BIND3:  s_next.rdata = {16'h0000, s_reg.bind3};
        A_LOWER:  s_next.rdata = {20'h00000, s_reg.lower};
        A_UPPER:  s_next.rdata = {20'h00000, s_reg.upper};
        A_INTVL:  s_next.rdata = s_reg.intvl;
        A_STATUS: s_next.rdata = {(ana[0] | ana[2]), 3'h0,
                                  ((ana[0] | ana[2]) ? s_reg.mean : 12'h000),
                                  13'h0000, s_reg.lvl};
        A_STORE:  s_next.rdata = {31'h0, s_reg.store};
        default:  s_next.rdata = 32'h0000_0000;
      endcase
    end
    if (aphase)
    begin
      s_next.addr = haddr_in[7:0];
      s_next.wr   = hwrite_in;
      s_next.rdw  = ~hwrite_in;
    end

    // Per-port change detection; runs after the bus so a set beats a clear
    for (int p = 0; p < 3; p++)
    begin
      if (s_reg.blank[p] != 17'h0 && s_reg.ms_tick)
        s_next.blank[p] = s_reg.blank[p] - 17'h1;
      nl  = s_reg.sy2[p];
      chg = (nl != s_reg.lvl[p]);
      if (ana[p])
      begin
        // Thresholds give hysteresis; between them the level holds
        if (s_reg.mean > s_reg.upper)
          nl = 1'b1;
        else if (s_reg.mean < s_reg.lower)
          nl = 1'b0;
        else
          nl = s_reg.lvl[p];
        chg = s_reg.upd && (nl != s_reg.lvl[p]);
      end
      if (chg && s_reg.blank[p] == 17'h0 && !s_reg.lock[p])
      begin
        s_next.lvl[p]    = nl;
        set[2 * p + 32'(nl)] = 1'b1;
        if (single_mode)
          s_next.lock[p] = 1'b1;
        else if (!cont_mode)
          s_next.blank[p] = s_reg.intvl[16:0] + 17'(BLANK_ADD);
      end
    end

    // Serve the lowest pending event, one per cycle
    for (int i = 5; i >= 0; i--)
    begin
      if (s_reg.pend[i])
      begin
        found = 1'b1;
        idx   = i;
      end
    end
    c = codes[4 * idx +: 4];
    s_next.pend = s_reg.pend;
    if (found)
      s_next.pend[idx] = 1'b0;
    s_next.pend = s_next.pend | set;
    s_next.av   = found && (c != ACT_NONE);
    s_next.nv   = found && (c != ACT_NONE) && en[idx / 2];
    s_next.code = c;
    if (ana[idx / 2])
      s_next.nid = idx[0] ? 3'h6 : 3'h7;
    else
      s_next.nid = 3'(idx);

    // Decode the action code into motion requests
    s_next.run   = 1'b0;
    s_next.move  = 1'b0;
    s_next.dir   = DIR_FWD;
    s_next.decel = 1'b0;
    s_next.estop = 1'b0;
    s_next.off   = 1'b0;
    s_next.clr   = 1'b0;
    if (s_next.av)
    begin
      unique case (c)
        ACT_FWDR:  s_next.run = 1'b1;
        ACT_REVR:
        begin
          s_next.run = 1'b1;
          s_next.dir = DIR_REV;
        end
        ACT_TOGR:
        begin
          s_next.run = 1'b1;
          s_next.dir = DIR_TOG;
        end
        ACT_FWDM:  s_next.move = 1'b1;
        ACT_REVM:
        begin
          s_next.move = 1'b1;
          s_next.dir  = DIR_REV;
        end
        ACT_TOGM:
        begin
          s_next.move = 1'b1;
          s_next.dir  = DIR_TOG;
        end
        ACT_DECEL: s_next.decel = 1'b1;
        ACT_ESTOP: s_next.estop = 1'b1;
        ACT_OFF:   s_next.off   = 1'b1;
        ACT_CLR:   s_next.clr   = 1'b1;
        ACT_CLRM:
        begin
          s_next.clr  = 1'b1;
          s_next.move = 1'b1;
          s_next.dir  = DIR_REV;
        end
        ACT_CLRD:
        begin
          s_next.clr   = 1'b1;
          s_next.decel = 1'b1;
        end
        ACT_CLRE:
        begin
          s_next.clr   = 1'b1;
          s_next.estop = 1'b1;
        end
        default:   ;  // Codes 1 and 8 only notify
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Everything clears on reset: continuous mode, no bindings, no notify
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      s_reg        <= '0;
      s_reg.master_configuration   <= MASTER_CONFIGURATION_RST;
      s_reg.bind12 <= BIND_RST;
      s_reg.bind3  <= BIND_RST;
      s_reg.lower  <= LIM_RST;
      s_reg.upper  <= LIM_RST;
      s_reg.intvl  <= INTVL_RST;
    end
    else
      s_reg <= s_next;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hrdata_out              = s_reg.rdata;
  assign hreadyout_out           = ~s_reg.rdw;
  assign hresp_out               = 1'b0;
  assign adc_sample_out          = s_reg.smp;
  assign adc_channel_out         = s_reg.master_configuration[CHS_BIT];
  assign action_valid_out        = s_reg.av;
  assign action_code_out         = s_reg.code;
  assign motion_run_out          = s_reg.run;
  assign motion_move_out         = s_reg.move;
  assign dir_sel_out             = s_reg.dir;
  assign decel_stop_out          = s_reg.decel;
  assign estop_out               = s_reg.estop;
  assign motor_off_out           = s_reg.off;
  assign clear_pos_out           = s_reg.clr;
  assign change_notification_out = s_reg.nv;
  assign notify_event_out        = s_reg.nid;
  assign store_params_out        = s_reg.store;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  sequence s_rd_addr;
    aphase && !hwrite_in;
  endsequence
  sequence s_rd_data;
    !hreadyout_out ##1 hreadyout_out;
  endsequence

  read_wait_a: assert property (s_rd_addr |=> s_rd_data)
    else $error("read wait state wrong");
  zero_code_a: assert property (action_valid_out |-> action_code_out != ACT_NONE)
    else $error("action issued for code zero");
  notify_en_a: assert property (change_notification_out && notify_event_out[2:1] == 2'b00
                                |-> $past(s_reg.master_configuration[IE1_BIT]))
    else $error("port one notified while disabled");
  port_two_a: assert property ($changed(s_reg.lvl[1])
                               |-> s_reg.lvl[1] == $past(s_reg.sy2[1]))
    else $error("port two level not from its pin");
  analog_one_a: assert property (ana[0] && $past(ana[0]) && $changed(s_reg.lvl[0])
                                 |-> $past(s_reg.upd))
    else $error("analog level moved without a mean refresh");
  mean_cnt_a: assert property (s_reg.upd |-> $past(s_reg.acq_n) == 4'hf)
    else $error("mean published without 16 samples");
  blank_load_a: assert property (!cont_mode && !single_mode && !ana[0]
                                 && $rose(s_reg.pend[1])
                                 |-> s_reg.blank[0] == s_reg.intvl[16:0] + 17'h2)
    else $error("blanking not loaded with T+2");
  single_hold_a: assert property (s_reg.lock[0] && !s_reg.wr |=> s_reg.lock[0])
    else $error("single mode lock released without rewrite");
  run_fwd_a: assert property (action_valid_out && action_code_out == ACT_FWDR
                              |-> motion_run_out && dir_sel_out == DIR_FWD)
    else $error("forward run not requested");
  store_req_a: assert property (s_reg.wr && s_reg.addr == A_STORE && hwdata_in[0]
                                |=> store_params_out)
    else $error("store request not raised");
  reset_def_a: assert property ($past(reset_in) |-> s_reg.intvl == 32'h0
                                && s_reg.bind12 == 16'h0 && s_reg.master_configuration == 16'h0)
    else $error("reset defaults wrong");

endmodule
`default_nettype wire

// ### include/seau_pkg.sv
// Constants shared by the sensor event action unit.
// Assumes a single 25 MHz system clock and a word-wide AHB-Lite register window.
`default_nettype none
package seau_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ     = 25_000_000;
  localparam int ADC_HZ     = 50_000;
  localparam int REFRESH_HZ = 1000;
  localparam int SMP_CYC    = CLK_HZ / ADC_HZ;      // Cycles per conversion
  localparam int MS_CYC     = CLK_HZ / REFRESH_HZ;  // Cycles per millisecond
  localparam int AVG_N      = 16;                   // Samples per mean
  localparam int AVG_SH     = 4;                    // log2 of AVG_N
  localparam int INTVL_MAX  = 60000;                // Above this: single mode
  localparam int BLANK_ADD  = 2;                    // T+1 ms, rounded up
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_MASTER_CONFIGURATION   = 8'h00;
  localparam logic [7:0] A_BIND12 = 8'h04;
  localparam logic [7:0] A_BIND3  = 8'h08;
  localparam logic [7:0] A_LOWER  = 8'h0c;
  localparam logic [7:0] A_UPPER  = 8'h10;
  localparam logic [7:0] A_INTVL  = 8'h14;
  localparam logic [7:0] A_STATUS = 8'h18;
  localparam logic [7:0] A_STORE  = 8'h1c;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int ANE_BIT = 15;  // analog_enable_bit
  localparam int CHS_BIT = 14;  // channel_select_bit
  localparam int IE1_BIT = 0;   // port_one_notify_enable
  localparam int IE2_BIT = 1;   // port_two_notify_enable
  localparam int IE3_BIT = 2;   // Port three notify enable
  localparam logic [15:0] MASTER_CONFIGURATION_RST  = 16'h0000;
  localparam logic [15:0] BIND_RST  = 16'h0000;
  localparam logic [11:0] LIM_RST   = 12'h000;
  localparam logic [31:0] INTVL_RST = 32'h0000_0000;
  // ----------------------------------------------------------------
  // Action codes
  // ----------------------------------------------------------------
  localparam logic [3:0] ACT_NONE  = 4'h0;
  localparam logic [3:0] ACT_REVR  = 4'h2;
  localparam logic [3:0] ACT_DECEL = 4'h3;
  localparam logic [3:0] ACT_ESTOP = 4'h4;
  localparam logic [3:0] ACT_REVM  = 4'h5;
  localparam logic [3:0] ACT_CLR   = 4'h6;
  localparam logic [3:0] ACT_CLRM  = 4'h7;
  localparam logic [3:0] ACT_TOGM  = 4'h9;
  localparam logic [3:0] ACT_FWDR  = 4'ha;
  localparam logic [3:0] ACT_CLRD  = 4'hb;
  localparam logic [3:0] ACT_CLRE  = 4'hc;
  localparam logic [3:0] ACT_FWDM  = 4'hd;
  localparam logic [3:0] ACT_TOGR  = 4'he;
  localparam logic [3:0] ACT_OFF   = 4'hf;
  // Direction requested from the motion engine
  typedef enum logic [1:0] {DIR_FWD, DIR_REV, DIR_TOG} seau_dir_t;
endpackage
`default_nettype wire

// ### verif/seau_sensor_model.sv
// Far side model: sensor pins, converter result and store acknowledge.
// Assumes the bench sets the pin levels and the analog value.
`timescale 1ns/1ps
`default_nettype none
module seau_sensor_model (
  // Clock and bench settings
  input  wire logic        clk_in,
  input  wire logic [2:0]  level_in,
  input  wire logic [11:0] analog_in,
  // Device side
  input  wire logic        adc_sample_in,
  input  wire logic        store_req_in,
  output logic      [2:0]  pin_out,
  output logic      [11:0] adc_data_out,
  output logic             store_ack_out
);
  logic [3:0] req_d = 4'h0;
  // Inverted outside a sample, so a late capture shows up as a wrong mean
  assign adc_data_out = adc_sample_in ? analog_in : ~analog_in;
  // Pins pass one flop; a store is acknowledged slowly, five cycles on
  always_ff @(posedge clk_in)
  begin
    pin_out       <= level_in;
    req_d         <= {req_d[2:0], store_req_in};
    store_ack_out <= store_req_in & req_d[3];
  end
endmodule
`default_nettype wire

// ### verif/testbench.sv
// Self-checking bench for the sensor event action unit.
// Assumes seau_core with a 9000-cycle millisecond and the sensor model.
`timescale 1ns/1ps
`default_nettype none
module testbench import seau_pkg::*;;
  localparam int MS = 9000;
  logic        sys_clk_in = 0, reset_in = 1, hsel = 0, hwrite = 0, got;
  logic [1:0]  htrans = 0, dsel;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q, r;
  logic        hready, smp, av, mrun, mmove, dstop, estop, moff, clr, note, store, ack;
  logic [3:0]  code;
  logic        resp, chn;
  logic [2:0]  nev, pins, lv = 0;
  logic [11:0] ana = 12'd3000, adc;
  logic [7:0]  tbl [16] = '{8'h00, 8'h00, 8'h81, 8'h20, 8'h10, 8'h41, 8'h04, 8'h45,
                            8'h00, 8'h42, 8'h80, 8'h24, 8'h14, 8'h40, 8'h82, 8'h08};
  int          fail_count = 0, samples_checked = 0, seed = 6;
  // Design and far side
  seau_core #(.MS_CYCLES(MS)) seau_core_inst (.sys_clk_in, .reset_in, .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010),
    .hwdata_in(hwdata), .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
    .hresp_out(resp), .sensor_port_one_in(pins[0]), .sensor_port_two_in(pins[1]),
    .sensor_port_three_in(pins[2]), .adc_data_in(adc), .adc_sample_out(smp),
    .adc_channel_out(chn), .action_valid_out(av), .action_code_out(code),
    .motion_run_out(mrun), .motion_move_out(mmove), .dir_sel_out(dsel),
    .decel_stop_out(dstop), .estop_out(estop), .motor_off_out(moff),
    .clear_pos_out(clr), .change_notification_out(note), .notify_event_out(nev),
    .store_params_out(store), .store_ack_in(ack));
  seau_sensor_model seau_sensor_model_inst (.clk_in(sys_clk_in), .level_in(lv),
    .analog_in(ana), .adc_sample_in(smp), .store_req_in(store), .pin_out(pins),
    .adc_data_out(adc), .store_ack_out(ack));
  // 25 MHz clock
  always #20 sys_clk_in = ~sys_clk_in;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One single AHB-Lite transfer; read data lands in q
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h0, a};
    @(posedge sys_clk_in);
    while (hready !== 1'b1) @(posedge sys_clk_in);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge sys_clk_in);
    while (hready !== 1'b1) @(posedge sys_clk_in);
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic pin(input logic [2:0] v);
    @(posedge sys_clk_in);
    lv <= v;
  endtask
  // Waits for an action or notification pulse and stops in its cycle
  task automatic ev(input int lim);
    got = 0;
    repeat (lim)
    begin
      @(posedge sys_clk_in);
      #1;
      if ((av | note) === 1'b1)
      begin
        got = 1;
        break;
      end
    end
  endtask
  task automatic see(input logic n, input logic [2:0] id, input logic [7:0] vec);
    chk({got, note, nev, mrun, mmove, dstop, estop, moff, clr, dsel}, {1'b1, n, id, vec});
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard, well beyond the longest analog and blanking waits
  initial
  begin
    repeat (100000) @(posedge sys_clk_in);
    fail_count++;
    final_report();
  end
  // Main sequence
  initial
  begin
    repeat (2) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    rd(A_MASTER_CONFIGURATION, 0);
    rd(A_INTVL, 0);
    rd(8'h20, 0);
    repeat (4)
    begin
      r = $random(seed);
      bus(1, A_BIND12, r);
      rd(A_BIND12, {16'h0, r[15:0]});
      bus(1, A_UPPER, r);
      rd(A_UPPER, {20'h0, r[11:0]});
    end
    // Codes 1 to 15 on both port one edges, code 0 on the rise only, continuous sampling
    bus(1, A_MASTER_CONFIGURATION, 32'h3);
    for (int c = 1; c < 16; c++)
    begin
      bus(1, A_BIND12, {24'h0, c[3:0], c[3:0]});
      pin(3'b001);
      ev(20);
      see(1, 1, tbl[c]);
      if (tbl[c] != 0) chk({av, code}, {1'b1, c[3:0]});
      pin(3'b000);
      ev(20);
      see(1, 0, tbl[c]);
    end
    bus(1, A_BIND12, 32'h0);
    pin(3'b001);
    ev(20);
    chk(got, 0);
    bus(1, A_MASTER_CONFIGURATION, 32'h0);
    bus(1, A_BIND12, 32'ha400);
    pin(3'b011);
    ev(20);
    see(0, 3, 8'h80);
    rd(A_STATUS, 32'h3);
    bus(1, A_MASTER_CONFIGURATION, 32'h2);
    pin(3'b001);
    ev(20);
    see(1, 2, 8'h10);
    // Intermittent then single sampling on port one
    bus(1, A_BIND12, 32'h0033);
    bus(1, A_INTVL, 1);
    pin(3'b000);
    ev(20);
    see(0, 0, 8'h20);
    pin(3'b001);
    ev(2 * MS - 20);
    chk(got, 0);
    ev(MS + 100);
    see(0, 1, 8'h20);
    bus(1, A_INTVL, 60001);
    pin(3'b000);
    // The blanking loaded by the last rise still runs, so the fall waits for it
    ev(3 * MS + 100);
    see(0, 0, 8'h20);
    pin(3'b001);
    ev(50);
    chk(got, 0);
    bus(1, A_BIND12, 32'h0033);
    ev(20);
    see(0, 1, 8'h20);
    bus(1, A_INTVL, 0);
    // Port one is still locked from single mode; rewriting its binding frees it
    bus(1, A_BIND12, 32'h0033);
    pin(3'b000);
    ev(20);
    see(0, 0, 8'h20);
    // Analog port one: crossings of the upper and lower limits
    bus(1, A_LOWER, 1000);
    bus(1, A_UPPER, 2000);
    bus(1, A_MASTER_CONFIGURATION, 32'h8001);
    ev(2 * MS + 500);
    see(1, 6, 8'h20);
    rd(A_STATUS, 32'h8bb8_0001);
    @(posedge sys_clk_in);
    ana <= 12'd500;
    ev(3 * MS);
    see(1, 7, 8'h20);
    // Store request held until the slow acknowledge
    bus(1, A_STORE, 1);
    #1;
    chk(store, 1);
    repeat (10) @(posedge sys_clk_in);
    rd(A_STORE, 0);
    // Steer the converter to port three; the bus answer stays OKAY
    bus(1, A_MASTER_CONFIGURATION, 32'hc000);
    #1;
    chk({resp, chn}, 2'b01);
    final_report();
  end
endmodule
`default_nettype wire
